// [core/gpib_pkg.sv]
// Constants, bus line bundles and state types for the instrument bus port.
// Assumes a 100 MHz clock and bus lines sampled as synchronous inputs.
package gpib_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SETTLE_NS = 2000;
  localparam logic [7:0] SETTLE_CYC =
    8'((T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------
  // Addressing and commands (7-bit, under attention)
  // ----------------------------------------
  localparam logic [5:0] MASTER_OFFSET = 6'h1e;
  localparam logic [6:0] LISTEN_GROUP = 7'h20;
  localparam logic [6:0] TALK_GROUP = 7'h40;
  localparam logic [6:0] SECONDARY_GROUP = 7'h60;
  localparam logic [6:0] CMD_UNLISTEN = 7'h3f;
  localparam logic [6:0] CMD_UNTALK = 7'h5f;
  localparam logic [6:0] CMD_GO_LOCAL = 7'h01;
  localparam logic [6:0] CMD_SEL_CLEAR = 7'h04;
  localparam logic [6:0] CMD_TRIGGER = 7'h08;
  localparam logic [6:0] CMD_LOCKOUT = 7'h11;
  localparam logic [6:0] CMD_ALL_CLEAR = 7'h14;
  localparam logic [6:0] CMD_POLL_ON = 7'h18;
  localparam logic [6:0] CMD_POLL_OFF = 7'h19;
  localparam logic [7:0] EXEC_CHAR = 8'h58;
  localparam int RQS_BIT = 6;

  // ----------------------------------------
  // Setups, buffering, reset values
  // ----------------------------------------
  localparam logic [7:0] SETUP_LAST = 8'h63;
  localparam logic [7:0] STEP_RESET = 8'h00;
  localparam int RX_WIDTH = 8;
  localparam int RX_DEPTH = 8;

  // ----------------------------------------
  // Line bundles; a 1 means the line is asserted (pulled low)
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] dio;
    logic dav;
    logic nrfd;
    logic ndac;
    logic atn;
    logic ifc;
    logic ren;
    logic eoi;
  } bus_in_t;

  typedef struct packed {
    logic [7:0] dio;
    logic dav;
    logic nrfd;
    logic ndac;
    logic eoi;
    logic srq;
  } bus_drv_t;

  typedef enum logic [1:0] {
    AH_IDLE = 2'b00,
    AH_READY = 2'b01,
    AH_ACCEPT = 2'b10
  } ah_state_t;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_WAIT = 2'b01,
    SH_DAV = 2'b10
  } sh_state_t;

endpackage

// [core/gpib_device_interface.sv]
// Device-side instrument bus port: handshakes, addressing, poll, remote/local,
// clear, trigger and relay step pointer. Receive bytes pass an 8-word FIFO.
// Assumes bus lines are already synchronous to clk; open-collector drivers outside.
//
// What this block does
// - Source data bytes only while addressed to talk.
// - Own listen address while talker drops the talker state.
// - Basic talker; serial poll answered with status byte.
// - Accept data bytes only while addressed to listen.
// - Own talk address while listener drops the listener state.
// - Only primary addresses; secondary addresses are ignored.
// - No parallel poll; no poll response line is ever driven.
// - Service request line can be asserted to call the controller.
// - Remote/local follow remote enable, addressing, go-local and lockout.
// - Selected or universal device clear reinitialises the device.
// - Group execute trigger starts a setup change.
// - Never controller; attention and interface clear never driven.
// - Source handshake: wait ready, assert valid, hold until all accept.
// - Acceptor handshake: release not-ready when able, not-accepted after latch.
// - Lines are only pulled low or released.
// - Each valid trigger sends next setup to relays and advances pointer.
// - Relay step pointer separate from edit pointer, zero at power-up.
// - Switch above thirty: master, bus address is switch minus thirty.
// - After illegal command, ignore input through next execute character.
`timescale 1ns/1ns

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  logic [AW-1:0] rd_nxt;
  logic [AW:0] left;
  logic [WIDTH-1:0] head_r;
  logic head_valid_r;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
  // Head word is registered so the outputs leave flip-flops
  assign rd_nxt = !pop ? rd_r : (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
  assign left = cnt_r - (AW + 1)'(pop);
  assign out_valid = head_valid_r;
  assign out_data = head_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      head_r <= '0;
      head_valid_r <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      rd_r <= rd_nxt;
      head_valid_r <= (left != '0) || push;
      head_r <= (left == '0) ? in_data : mem[rd_nxt];
      cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule // rx_fifo

// ----------------------------------------
// Device interface
// ----------------------------------------
module gpib_device_interface
  import gpib_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire bus_in_t bus_in,
  output bus_drv_t bus_out,
  output bus_drv_t bus_oe,
  input wire logic [5:0] addr_switch,
  input wire logic [7:0] tx_data,
  input wire logic tx_eoi,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic bad_cmd,
  input wire logic [7:0] status_byte,
  input wire logic srq_req,
  input wire logic trig_enable,
  output logic master_mode,
  output logic [4:0] bus_addr,
  output logic talk_addr,
  output logic listen_addr,
  output logic remote,
  output logic lockout,
  output logic dev_clear,
  output logic relay_load,
  output logic [7:0] relay_step
);

  // ----------------------------------------
  // Address capture after reset release
  // ----------------------------------------
  logic addr_done_r;
  logic master_r;
  logic [4:0] addr_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_done_r <= 1'b0;
      master_r <= 1'b0;
      addr_r <= 5'h00;
    end else if (!addr_done_r) begin
      addr_done_r <= 1'b1;
      master_r <= (addr_switch > MASTER_OFFSET);
      addr_r <= (addr_switch > MASTER_OFFSET) ?
        5'(addr_switch - MASTER_OFFSET) : addr_switch[4:0];
    end
  end

  assign master_mode = master_r;
  assign bus_addr = addr_r;

  // ----------------------------------------
  // Acceptor handshake
  // ----------------------------------------
  ah_state_t ah_r;
  ah_state_t ah_nxt;
  logic listen_r;
  logic talk_r;
  logic acc_on;
  logic fifo_in_ready;
  logic got_r;
  logic got_cmd_r;
  logic [7:0] byte_r;
  logic nrfd_oe_r;
  logic ndac_oe_r;

  assign acc_on = bus_in.atn || listen_r;

  always_comb begin
    ah_nxt = ah_r;
    case (ah_r)
      AH_IDLE: begin
        if (acc_on && (bus_in.atn || fifo_in_ready) && !bus_in.dav) begin
          ah_nxt = AH_READY;
        end
      end
      AH_READY: begin
        if (!acc_on) begin
          ah_nxt = AH_IDLE;
        end else if (bus_in.dav) begin
          ah_nxt = AH_ACCEPT;
        end
      end
      AH_ACCEPT: begin
        if (!bus_in.dav) begin
          ah_nxt = AH_IDLE;
        end
      end
      default: ah_nxt = AH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ah_r <= AH_IDLE;
      nrfd_oe_r <= 1'b0;
      ndac_oe_r <= 1'b0;
      got_r <= 1'b0;
      got_cmd_r <= 1'b0;
      byte_r <= 8'h00;
    end else begin
      ah_r <= ah_nxt;
      nrfd_oe_r <= acc_on && (ah_nxt != AH_READY);
      ndac_oe_r <= acc_on && (ah_nxt != AH_ACCEPT);
      got_r <= (ah_r == AH_READY) && (ah_nxt == AH_ACCEPT);
      if ((ah_r == AH_READY) && (ah_nxt == AH_ACCEPT)) begin
        byte_r <= bus_in.dio;
        got_cmd_r <= bus_in.atn;
      end
    end
  end

  // ----------------------------------------
  // Command decode, addressing, remote/local
  // ----------------------------------------
  logic [6:0] cmd;
  logic is_cmd;
  logic my_listen;
  logic my_talk;
  logic clr_hit;
  logic get_hit;
  logic spoll_r;
  logic remote_r;
  logic lockout_r;
  logic clear_r;

  assign cmd = byte_r[6:0];
  assign is_cmd = got_r && got_cmd_r && (cmd < SECONDARY_GROUP);
  assign my_listen = is_cmd && (cmd == (LISTEN_GROUP | 7'(addr_r)));
  assign my_talk = is_cmd && (cmd == (TALK_GROUP | 7'(addr_r)));
  assign clr_hit = is_cmd && ((cmd == CMD_ALL_CLEAR) ||
    ((cmd == CMD_SEL_CLEAR) && listen_r));
  assign get_hit = is_cmd && (cmd == CMD_TRIGGER) && listen_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      listen_r <= 1'b0;
      talk_r <= 1'b0;
    end else if (bus_in.ifc) begin
      listen_r <= 1'b0;
      talk_r <= 1'b0;
    end else begin
      if (my_listen) begin
        listen_r <= 1'b1;
        talk_r <= 1'b0;
      end else if (my_talk) begin
        talk_r <= 1'b1;
        listen_r <= 1'b0;
      end else if (is_cmd && (cmd == CMD_UNLISTEN)) begin
        listen_r <= 1'b0;
      end else if (is_cmd && (cmd[6:5] == 2'b10)) begin
        talk_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spoll_r <= 1'b0;
    end else if (bus_in.ifc || (is_cmd && (cmd == CMD_POLL_OFF))) begin
      spoll_r <= 1'b0;
    end else if (is_cmd && (cmd == CMD_POLL_ON)) begin
      spoll_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remote_r <= 1'b0;
      lockout_r <= 1'b0;
    end else if (!bus_in.ren) begin
      remote_r <= 1'b0;
      lockout_r <= 1'b0;
    end else begin
      if (my_listen) begin
        remote_r <= 1'b1;
      end else if (is_cmd && (cmd == CMD_GO_LOCAL) && listen_r) begin
        remote_r <= 1'b0;
      end
      if (is_cmd && (cmd == CMD_LOCKOUT)) begin
        lockout_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clear_r <= 1'b0;
    end else begin
      clear_r <= clr_hit;
    end
  end

  // ----------------------------------------
  // Trigger and relay step pointer
  // ----------------------------------------
  logic [7:0] step_r;
  logic load_r;
  logic [7:0] load_step_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_r <= STEP_RESET;
      load_r <= 1'b0;
      load_step_r <= STEP_RESET;
    end else begin
      load_r <= get_hit && trig_enable;
      if (clr_hit) begin
        step_r <= STEP_RESET;
      end else if (get_hit && trig_enable) begin
        load_step_r <= step_r;
        step_r <= (step_r == SETUP_LAST) ? STEP_RESET : step_r + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Receive filter into FIFO
  // ----------------------------------------
  logic discard_r;
  logic rx_push;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      discard_r <= 1'b0;
    end else if (bad_cmd) begin
      discard_r <= 1'b1;
    end else if (clr_hit || (got_r && !got_cmd_r && (byte_r == EXEC_CHAR))) begin
      discard_r <= 1'b0;
    end
  end

  assign rx_push = got_r && !got_cmd_r && listen_r && !discard_r && !bad_cmd;

  rx_fifo #(
    .WIDTH(RX_WIDTH),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_data(byte_r),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // ----------------------------------------
  // Service request
  // ----------------------------------------
  logic rqs_r;
  logic sp_done;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rqs_r <= 1'b0;
    end else if (srq_req) begin
      rqs_r <= 1'b1;
    end else if (sp_done || clr_hit) begin
      rqs_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Source handshake
  // ----------------------------------------
  sh_state_t sh_r;
  logic talk_act;
  logic [7:0] sh_cnt_r;
  logic [7:0] tx_byte_r;
  logic tx_last_r;
  logic sh_poll_r;
  logic tx_ready_r;
  logic dav_oe_r;
  logic [7:0] dio_oe_r;
  logic eoi_oe_r;

  assign talk_act = talk_r && !bus_in.atn && !bus_in.ifc;
  assign sp_done = (sh_r == SH_DAV) && talk_act && !bus_in.ndac && sh_poll_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_r <= SH_IDLE;
      sh_cnt_r <= 8'h00;
      tx_byte_r <= 8'h00;
      tx_last_r <= 1'b0;
      sh_poll_r <= 1'b0;
    end else if (clr_hit || bus_in.ifc) begin
      sh_r <= SH_IDLE;
    end else begin
      case (sh_r)
        SH_IDLE: begin
          sh_cnt_r <= 8'h00;
          if (talk_act && spoll_r) begin
            tx_byte_r <= status_byte;
            tx_byte_r[RQS_BIT] <= rqs_r;
            tx_last_r <= 1'b0;
            sh_poll_r <= 1'b1;
            sh_r <= SH_WAIT;
          end else if (tx_valid && tx_ready_r) begin
            tx_byte_r <= tx_data;
            tx_last_r <= tx_eoi;
            sh_poll_r <= 1'b0;
            sh_r <= SH_WAIT;
          end
        end
        SH_WAIT: begin
          if (!talk_act) begin
            sh_cnt_r <= 8'h00;
          end else if (sh_cnt_r < SETTLE_CYC) begin
            sh_cnt_r <= sh_cnt_r + 8'h01;
          end else if (!bus_in.nrfd) begin
            sh_r <= SH_DAV;
          end
        end
        SH_DAV: begin
          if (!talk_act) begin
            sh_r <= SH_WAIT;
            sh_cnt_r <= 8'h00;
          end else if (!bus_in.ndac) begin
            sh_r <= sh_poll_r ? SH_DAV : SH_IDLE;
            if (sh_poll_r) begin
              sh_poll_r <= 1'b0;
            end
          end
        end
        default: sh_r <= SH_IDLE;
      endcase
      if (sh_r == SH_DAV && !sh_poll_r && bus_in.ndac == 1'b0 && talk_act) begin
        sh_r <= SH_IDLE;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_ready_r <= 1'b0;
      dav_oe_r <= 1'b0;
      dio_oe_r <= 8'h00;
      eoi_oe_r <= 1'b0;
    end else begin
      tx_ready_r <= (sh_r == SH_IDLE) && talk_r && !spoll_r &&
        !(tx_valid && tx_ready_r);
      dav_oe_r <= talk_act && (sh_r == SH_DAV) && !(!bus_in.ndac);
      dio_oe_r <= (talk_act && (sh_r != SH_IDLE)) ? tx_byte_r : 8'h00;
      eoi_oe_r <= talk_act && (sh_r != SH_IDLE) && tx_last_r;
    end
  end

  // ----------------------------------------
  // Line drive; levels always low, enables pull
  // ----------------------------------------
  logic srq_oe_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srq_oe_r <= 1'b0;
      bus_out <= '0;
    end else begin
      srq_oe_r <= rqs_r;
      bus_out <= '0;
    end
  end

  // No attention, clear or poll response drivers exist here.
  assign bus_oe = '{dio: dio_oe_r, dav: dav_oe_r, nrfd: nrfd_oe_r,
    ndac: ndac_oe_r, eoi: eoi_oe_r, srq: srq_oe_r};
  assign tx_ready = tx_ready_r;
  assign talk_addr = talk_r;
  assign listen_addr = listen_r;
  assign remote = remote_r;
  assign lockout = lockout_r;
  assign dev_clear = clear_r;
  assign relay_load = load_r;
  assign relay_step = load_step_r;

endmodule // gpib_device_interface

// [bench/gpib_device_interface_asserts.sv]
// Checker for the instrument bus port, bound onto its top module.
// Assumes one clock domain and bus lines encoded as 1 = asserted.
`timescale 1ns/1ns
module gpib_device_interface_asserts
  import gpib_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire bus_in_t bus_in,
  input wire bus_drv_t bus_out,
  input wire bus_drv_t bus_oe,
  input wire logic [5:0] addr_switch,
  input wire logic master_mode,
  input wire logic [4:0] bus_addr,
  input wire logic talk_addr,
  input wire logic listen_addr,
  input wire logic dev_clear,
  input wire logic relay_load,
  input wire logic [7:0] relay_step
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // Step seen at the previous load
  // ----------------------------------------
  logic [7:0] prev_r;
  logic seen_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seen_r <= 1'b0;
      prev_r <= 8'h00;
    end else if (dev_clear) begin
      seen_r <= 1'b0;
    end else if (relay_load) begin
      seen_r <= 1'b1;
      prev_r <= relay_step;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_out_zero: assert property (bus_out == '0)
    else $error("driven level not low");
  a_role_excl: assert property (!(talk_addr && listen_addr))
    else $error("talker and listener at once");
  a_dav_talker: assert property (bus_oe.dav |-> talk_addr)
    else $error("data valid while not talker");
  a_dav_ready: assert property ($rose(bus_oe.dav) |-> $past(bus_in.nrfd) == 1'b0)
    else $error("data valid before ready");
  a_dav_hold: assert property (bus_oe.dav && bus_in.ndac && !bus_in.atn && !bus_in.ifc |=> bus_oe.dav)
    else $error("data valid dropped early");
  a_ndac_cause: assert property ($fell(bus_oe.ndac) && (bus_in.atn || listen_addr) |-> $past(bus_in.dav))
    else $error("accepted without data valid");
  a_idle_release: assert property ((!bus_in.atn && !listen_addr) [*2] |-> !bus_oe.nrfd && !bus_oe.ndac)
    else $error("handshake held while idle");
  a_step_next: assert property (relay_load && seen_r |->
    relay_step == ((prev_r == SETUP_LAST) ? 8'h00 : prev_r + 8'h01))
    else $error("step not advanced by one");
  a_step_zero: assert property ($rose(resetn) |-> relay_step == STEP_RESET)
    else $error("step not zero after reset");
  a_master_addr: assert property (master_mode |-> bus_addr == 5'(addr_switch - MASTER_OFFSET))
    else $error("master address wrong");
  a_clear_pulse: assert property (dev_clear |=> !dev_clear)
    else $error("clear pulse too long");

  c_load: cover property (relay_load);
  c_source: cover property ($rose(bus_oe.dav));
  c_srq: cover property ($rose(bus_oe.srq));
endmodule // gpib_device_interface_asserts

bind gpib_device_interface gpib_device_interface_asserts chk (.clk, .resetn, .bus_in, .bus_out, .bus_oe,
  .addr_switch, .master_mode, .bus_addr, .talk_addr, .listen_addr, .dev_clear, .relay_load, .relay_step);

// [bench/gpib_controller_model.sv]
// Behavioural bus controller: sends bytes, reads bytes, resolves the lines.
// Assumes the device's drive enables; released lines read as 0 (pull-up).
`timescale 1ns/1ns
module gpib_controller_model
  import gpib_pkg::*;
(
  input wire logic clk,
  input wire bus_drv_t dev,
  output bus_in_t line
);
  bus_in_t ctl;

  assign line = ctl | {dev.dio, dev.dav, dev.nrfd, dev.ndac, 3'b000, dev.eoi};

  initial begin
    ctl = '0;
    ctl.atn = 1'b1;
    ctl.ren = 1'b1;
  end

  // Source one byte; waits for ready, holds valid until accepted
  task automatic put(input logic a, input logic [7:0] d);
    int n;
    repeat (2) @(posedge clk);
    ctl.atn <= a;
    ctl.dio <= d;
    n = 0;
    while (line.nrfd !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    ctl.dav <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (line.ndac !== 1'b0 && n < 300);
    ctl.dav <= 1'b0;
    ctl.dio <= 8'h00;
  endtask

  // Accept one byte from the talker
  task automatic get(output logic [7:0] d, output logic e);
    int n;
    @(posedge clk);
    ctl.atn <= 1'b0;
    ctl.ndac <= 1'b1;
    ctl.nrfd <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (line.dav !== 1'b1 && n < 400);
    d = line.dio;
    e = line.eoi;
    ctl.nrfd <= 1'b1;
    ctl.ndac <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (line.dav !== 1'b0 && n < 300);
    ctl.nrfd <= 1'b0;
    ctl.atn <= 1'b1;
  endtask
endmodule // gpib_controller_model

// [bench/gpib_device_interface_tb.sv]
// Self-checking bench for the instrument bus port.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ns
module gpib_device_interface_tb
  import gpib_pkg::*;
;
  typedef struct packed {
    logic [7:0] cmd;
    logic talk;
    logic lis;
    logic rem;
  } row_t;

  logic clk, resetn, tx_eoi, tx_valid, tx_ready, rx_valid, rx_ready, bad_cmd, srq_req, trig_enable;
  logic master_mode, talk_addr, listen_addr, remote, lockout, dev_clear, relay_load, e;
  logic [5:0] addr_switch;
  logic [4:0] bus_addr;
  logic [7:0] tx_data, rx_data, status_byte, relay_step, last_step, d;
  bus_in_t bus_in;
  bus_drv_t bus_out, bus_oe;
  int num_errors = 0;
  int n_tests = 0;
  int loads = 0;
  int clears = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];
  row_t rows [8] = '{'{8'h32, 1'b0, 1'b1, 1'b1}, '{8'h52, 1'b1, 1'b0, 1'b1}, '{8'h32, 1'b0, 1'b1, 1'b1},
    '{8'h25, 1'b0, 1'b1, 1'b1}, '{8'h45, 1'b0, 1'b1, 1'b1}, '{8'h72, 1'b0, 1'b1, 1'b1},
    '{8'h3f, 1'b0, 1'b0, 1'b1}, '{8'h01, 1'b0, 1'b0, 1'b1}};

  gpib_device_interface uut (.clk(clk), .resetn(resetn), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .addr_switch(addr_switch), .tx_data(tx_data), .tx_eoi(tx_eoi),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .bad_cmd(bad_cmd), .status_byte(status_byte), .srq_req(srq_req),
    .trig_enable(trig_enable), .master_mode(master_mode), .bus_addr(bus_addr), .talk_addr(talk_addr),
    .listen_addr(listen_addr), .remote(remote), .lockout(lockout), .dev_clear(dev_clear),
    .relay_load(relay_load), .relay_step(relay_step));
  gpib_controller_model u_ctl (.clk(clk), .dev(bus_oe), .line(bus_in));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse_in(input int which);
    if (which == 0) bad_cmd <= 1'b1;
    else srq_req <= 1'b1;
    @(posedge clk);
    bad_cmd <= 1'b0;
    srq_req <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (relay_load === 1'b1) begin
      loads++;
      last_step = relay_step;
    end
    if (dev_clear === 1'b1) clears++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) check(rx_data, exp_q.pop_front());
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    resetn = 1'b0;
    addr_switch = 6'h12;
    {tx_data, tx_eoi, tx_valid, bad_cmd, srq_req} = '0;
    rx_ready = 1'b1;
    trig_enable = 1'b1;
    status_byte = 8'h05;
    tick(16);
    resetn <= 1'b1;
    tick(3);
    check(master_mode, 1'b0);
    check(bus_addr, 5'h12);
    check(relay_step, STEP_RESET);
    for (int i = 0; i < 8; i++) begin
      u_ctl.put(1'b1, rows[i].cmd);
      tick(3);
      check(talk_addr, rows[i].talk);
      check(listen_addr, rows[i].lis);
      check(remote, rows[i].rem);
    end
    // ----------------------------------------
    // Receive buffer, bad command, unaddressed data
    // ----------------------------------------
    u_ctl.put(1'b1, 8'h32);
    rx_ready <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      exp_q.push_back(8'h30 + 8'(i));
      u_ctl.put(1'b0, 8'h30 + 8'(i));
    end
    tick(4);
    check(bus_oe.nrfd, 1'b1);
    rx_ready <= 1'b1;
    exp_q.push_back(8'h41);
    u_ctl.put(1'b0, 8'h41);
    pulse_in(0);
    u_ctl.put(1'b0, 8'h42);
    u_ctl.put(1'b0, EXEC_CHAR);
    exp_q.push_back(8'h43);
    u_ctl.put(1'b0, 8'h43);
    u_ctl.put(1'b1, 8'h3f);
    u_ctl.put(1'b0, 8'h77);
    tick(12);
    check(exp_q.size(), 0);
    // ----------------------------------------
    // Triggers, wrap, clear
    // ----------------------------------------
    u_ctl.put(1'b1, 8'h32);
    for (int k = 0; k < 101; k++) begin
      u_ctl.put(1'b1, 8'h08);
      tick(4);
      check(last_step, 8'(k % 100));
    end
    trig_enable <= 1'b0;
    u_ctl.put(1'b1, 8'h08);
    tick(4);
    check(loads, 101);
    trig_enable <= 1'b1;
    u_ctl.put(1'b1, 8'h14);
    u_ctl.put(1'b1, 8'h08);
    tick(4);
    check(clears, 1);
    check(last_step, 8'h00);
    u_ctl.put(1'b1, 8'h04);
    tick(4);
    check(clears, 2);
    u_ctl.put(1'b1, 8'h01);
    tick(3);
    check(remote, 1'b0);
    u_ctl.put(1'b1, 8'h11);
    tick(3);
    check(lockout, 1'b1);
    u_ctl.ctl.ren <= 1'b0;
    tick(3);
    check(lockout, 1'b0);
    // ----------------------------------------
    // Talker and serial poll
    // ----------------------------------------
    tx_data <= 8'ha5;
    tx_eoi <= 1'b1;
    tx_valid <= 1'b1;
    tick(20);
    check(tx_ready, 1'b0);
    check(bus_oe.dio, 8'h00);
    u_ctl.put(1'b1, 8'h52);
    for (int i = 0; i < 50 && tx_valid; i++) begin
      @(posedge clk);
      if (tx_ready === 1'b1) tx_valid <= 1'b0;
    end
    check(tx_valid, 1'b0);
    u_ctl.get(d, e);
    check(d, 8'ha5);
    check(e, 1'b1);
    pulse_in(1);
    tick(2);
    check(bus_oe.srq, 1'b1);
    u_ctl.put(1'b1, 8'h18);
    u_ctl.get(d, e);
    check(d, 8'h45);
    u_ctl.put(1'b1, 8'h19);
    tick(3);
    check(bus_oe.srq, 1'b0);
    u_ctl.ctl.ifc <= 1'b1;
    tick(2);
    u_ctl.ctl.ifc <= 1'b0;
    check(talk_addr, 1'b0);
    // ----------------------------------------
    // Reset again as master
    // ----------------------------------------
    resetn <= 1'b0;
    addr_switch <= 6'h30;
    u_ctl.ctl.ren <= 1'b1;
    tick(2);
    resetn <= 1'b1;
    tick(3);
    check(master_mode, 1'b1);
    check(bus_addr, 5'h12);
    check(relay_step, STEP_RESET);
    u_ctl.put(1'b1, 8'h32);
    tick(3);
    check(listen_addr, 1'b1);
    give_verdict();
  end
endmodule // gpib_device_interface_tb
